/* hbfc_pkg.sv */
// Constants, types and register map of the bridge fault controller
// How it works
// - Power-down wins; bridge outputs float
// - Power-down releases all three fault lines
// - Reset ignores inputs, drives low, clears latch
// - Fault lines only pull low or release
// - Short circuit latches floating shutdown until reset
// - Other faults drive low, clear when gone
// - No input toggling counts as illegal input
// - Shutdown codes: illegal, short, heat, low supply
// - Running codes: normal, heat warning; rest reserved
// - Thermal trip above 150C, resume at 130C
// - Low regulator holds shutdown until recovered
// - Pos/neg decode; equal inputs are illegal
package hbfc_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_IRQ_STAT = 8'h08;
  localparam logic [7:0]  REG_IRQ_MASK = 8'h0c;

  // Control register: bit 0 mutes the bridge in normal operation
  localparam int          CTRL_MUTE    = 0;
  localparam logic        CTRL_RST     = 1'h0;

  // Status register fields
  localparam int          ST_SHUT      = 0;
  localparam int          ST_CODE_LSB  = 1;
  localparam int          ST_WARN      = 3;
  localparam int          ST_LATCH     = 4;
  localparam int          ST_STATE_LSB = 5;
  localparam int          ST_LINE_LSB  = 7;

  // Interrupt event bits, same layout in status and mask
  localparam int          EV_W         = 5;
  localparam int          EV_ILLEGAL   = 0;
  localparam int          EV_SHORT     = 1;
  localparam int          EV_OVERTEMP  = 2;
  localparam int          EV_LOWREG    = 3;
  localparam int          EV_WARN      = 4;
  localparam logic [4:0]  EV_RST       = 5'h00;

  // ----------------------------------------------------------------
  // Fault codes {hi, lo} as seen on the lines
  // ----------------------------------------------------------------
  localparam logic [1:0]  CODE_ILLEGAL  = 2'h0;
  localparam logic [1:0]  CODE_SHORT    = 2'h1;
  localparam logic [1:0]  CODE_OVERTEMP = 2'h2;
  localparam logic [1:0]  CODE_LOWREG   = 2'h3;
  localparam logic [1:0]  CODE_WARN     = 2'h2;
  localparam logic [1:0]  CODE_NORMAL   = 2'h3;

  // ----------------------------------------------------------------
  // Thermal thresholds, sensor reads whole degrees C
  // ----------------------------------------------------------------
  localparam int          TEMP_W       = 8;
  localparam logic [7:0]  TEMP_SHUT    = 8'h96;  // 150 C
  localparam logic [7:0]  TEMP_WARN    = 8'h82;  // 130 C

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 40;
  localparam int          ACT_TIMEOUT_NS = 20000;
  localparam int          ACT_TIMEOUT_CYC = ACT_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int          CNT_W          = 10;

  typedef enum logic [1:0] {
    ST_OFF   = 2'h0,
    ST_HOLD  = 2'h1,
    ST_RUN   = 2'h3,
    ST_FAULT = 2'h2
  } hbfc_state_t;

endpackage : hbfc_pkg

/* hbfc_pwm_check.sv */
// Per-side PWM input checker: illegal pair and loss of toggling
`timescale 1ns/1ps
module hbfc_pwm_check (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Checker enable, low while bridge reset or power-down
  input  wire logic arm,
  // Complementary input pair
  input  wire logic pos,
  input  wire logic neg,
  // Registered illegal flag
  output logic      bad
);

  localparam logic [hbfc_pkg::CNT_W-1:0] LIMIT =
    hbfc_pkg::CNT_W'(hbfc_pkg::ACT_TIMEOUT_CYC);

  logic                        prev_q, prev_d;
  logic [hbfc_pkg::CNT_W-1:0]  cnt_q,  cnt_d;
  logic                        bad_q,  bad_d;

  always_comb begin
    prev_d = pos;
    if (!arm || (pos != prev_q)) begin
      cnt_d = '0;
    end else if (cnt_q == LIMIT) begin
      cnt_d = cnt_q;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
    // Equal pair or a stalled pair both count as illegal
    bad_d = arm && ((pos == neg) || (cnt_q == LIMIT));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
      cnt_q  <= '0;
      bad_q  <= 1'b0;
    end else begin
      prev_q <= prev_d;
      cnt_q  <= cnt_d;
      bad_q  <= bad_d;
    end
  end

  assign bad = bad_q;

endmodule : hbfc_pwm_check

/* hbfc_top.sv */
// Bridge fault controller: output control, fault coding, registers
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
module hbfc_top (
  // Clock and reset
  input  wire logic                         SYS_CLK,
  input  wire logic                         RST_N,
  // Control pins
  input  wire logic                         POWER_DOWN_N,
  input  wire logic                         BRIDGE_RESET_N,
  // PWM inputs
  input  wire logic                         SIDE_A_POS_IN,
  input  wire logic                         SIDE_A_NEG_IN,
  input  wire logic                         SIDE_B_POS_IN,
  input  wire logic                         SIDE_B_NEG_IN,
  // Sensors
  input  wire logic [hbfc_pkg::TEMP_W-1:0]  TEMP_SENSE,
  input  wire logic                         REGULATOR_OUT_A_OK,
  input  wire logic                         REGULATOR_OUT_B_OK,
  input  wire logic                         OVER_CURRENT_A,
  input  wire logic                         OVER_CURRENT_B,
  // Bridge outputs, floating while enable low
  output logic                              BRIDGE_OUT_A,
  output logic                              BRIDGE_OUT_A_OE,
  output logic                              BRIDGE_OUT_B,
  output logic                              BRIDGE_OUT_B_OE,
  // Open-drain fault lines
  output logic                              SHUTDOWN_N_O,
  output logic                              SHUTDOWN_N_OE,
  input  wire logic                         SHUTDOWN_N_I,
  output logic                              FAULT_CODE_HI_O,
  output logic                              FAULT_CODE_HI_OE,
  input  wire logic                         FAULT_CODE_HI_I,
  output logic                              FAULT_CODE_LO_O,
  output logic                              FAULT_CODE_LO_OE,
  input  wire logic                         FAULT_CODE_LO_I,
  // Wishbone slave
  input  wire logic                         WB_CYC_I,
  input  wire logic                         WB_STB_I,
  input  wire logic                         WB_WE_I,
  input  wire logic [hbfc_pkg::ADDR_W-1:0]  WB_ADR_I,
  input  wire logic [3:0]                   WB_SEL_I,
  input  wire logic [hbfc_pkg::DATA_W-1:0]  WB_DAT_I,
  output logic      [hbfc_pkg::DATA_W-1:0]  WB_DAT_O,
  output logic                              WB_ACK_O,
  // Interrupt
  output logic                              IRQ
);

  // ----------------------------------------------------------------
  // Input checkers, one per bridge side
  // ----------------------------------------------------------------
  logic [1:0] pos_in;
  logic [1:0] neg_in;
  logic [1:0] side_bad;
  logic       armed;

  assign pos_in = {SIDE_B_POS_IN, SIDE_A_POS_IN};
  assign neg_in = {SIDE_B_NEG_IN, SIDE_A_NEG_IN};
  // Checkers idle in reset so a fresh start gets a full timeout
  assign armed  = POWER_DOWN_N && BRIDGE_RESET_N;

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_side
      hbfc_pwm_check u_check (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .arm   (armed),
        .pos   (pos_in[s]),
        .neg   (neg_in[s]),
        .bad   (side_bad[s])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Fault conditions
  // ----------------------------------------------------------------
  logic illegal;
  logic low_reg;
  logic over_cur;
  logic hot_q,   hot_d;
  logic latch_q, latch_d;
  logic warn;

  assign illegal  = |side_bad;
  assign low_reg  = !REGULATOR_OUT_A_OK || !REGULATOR_OUT_B_OK;
  assign over_cur = OVER_CURRENT_A || OVER_CURRENT_B;
  assign warn     = TEMP_SENSE > hbfc_pkg::TEMP_WARN;

  always_comb begin
    // Trip above the shutdown point, release only at the warning point
    if (TEMP_SENSE > hbfc_pkg::TEMP_SHUT) begin
      hot_d = 1'b1;
    end else if (TEMP_SENSE <= hbfc_pkg::TEMP_WARN) begin
      hot_d = 1'b0;
    end else begin
      hot_d = hot_q;
    end
    // Reset and power-down clear the latch and hold it clear
    if (!POWER_DOWN_N || !BRIDGE_RESET_N) begin
      latch_d = 1'b0;
    end else if (over_cur) begin
      latch_d = 1'b1;
    end else begin
      latch_d = latch_q;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      hot_q   <= 1'b0;
      latch_q <= 1'b0;
    end else begin
      hot_q   <= hot_d;
      latch_q <= latch_d;
    end
  end

  // ----------------------------------------------------------------
  // Operating state and pin drive
  // ----------------------------------------------------------------
  logic       fault_any;
  logic [1:0] cause;

  assign fault_any = latch_q || low_reg || hot_q || illegal;

  // Short circuit first, then supply, heat and input faults
  always_comb begin
    if (latch_q) begin
      cause = hbfc_pkg::CODE_SHORT;
    end else if (low_reg) begin
      cause = hbfc_pkg::CODE_LOWREG;
    end else if (hot_q) begin
      cause = hbfc_pkg::CODE_OVERTEMP;
    end else begin
      cause = hbfc_pkg::CODE_ILLEGAL;
    end
  end

  hbfc_pkg::hbfc_state_t state_q, state_d;

  // Power-down beats reset, reset beats any fault
  always_comb begin
    state_d = state_q;
    case (state_q)
      hbfc_pkg::ST_OFF: begin
        if (POWER_DOWN_N) begin
          state_d = hbfc_pkg::ST_HOLD;
        end
      end
      hbfc_pkg::ST_HOLD: begin
        if (!POWER_DOWN_N) begin
          state_d = hbfc_pkg::ST_OFF;
        end else if (BRIDGE_RESET_N) begin
          state_d = hbfc_pkg::ST_RUN;
        end
      end
      hbfc_pkg::ST_RUN: begin
        if (!POWER_DOWN_N) begin
          state_d = hbfc_pkg::ST_OFF;
        end else if (!BRIDGE_RESET_N) begin
          state_d = hbfc_pkg::ST_HOLD;
        end else if (fault_any) begin
          state_d = hbfc_pkg::ST_FAULT;
        end
      end
      hbfc_pkg::ST_FAULT: begin
        if (!POWER_DOWN_N) begin
          state_d = hbfc_pkg::ST_OFF;
        end else if (!BRIDGE_RESET_N) begin
          state_d = hbfc_pkg::ST_HOLD;
        end else if (!fault_any) begin
          state_d = hbfc_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = hbfc_pkg::ST_OFF;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers and bus
  // ----------------------------------------------------------------
  logic                            ack_q,   ack_d;
  logic [hbfc_pkg::DATA_W-1:0]     rdat_q,  rdat_d;
  logic                            mute_q,  mute_d;
  logic [hbfc_pkg::EV_W-1:0]       mask_q,  mask_d;
  logic [hbfc_pkg::EV_W-1:0]       stat_q,  stat_d;
  logic                            irq_q,   irq_d;
  logic [2:0]                      line_q,  line_d;
  logic [hbfc_pkg::EV_W-1:0]       ev_now;
  logic [hbfc_pkg::DATA_W-1:0]     status_word;
  logic                            bus_req;
  logic                            wr_hit;

  // Pin drive state, registered so outputs come from flops
  logic [1:0]                      drv_q,   drv_d;
  logic [1:0]                      oe_q,    oe_d;
  logic                            sd_pull_q, sd_pull_d;
  logic [1:0]                      code_pull_q, code_pull_d;

  assign bus_req = WB_CYC_I && WB_STB_I;
  // Writes land on the edge at which the master sees ack high
  assign wr_hit  = bus_req && WB_WE_I && ack_q && WB_SEL_I[0];

  always_comb begin
    status_word = '0;
    status_word[hbfc_pkg::ST_SHUT] = sd_pull_q;
    status_word[hbfc_pkg::ST_CODE_LSB +: 2] = ~code_pull_q;
    status_word[hbfc_pkg::ST_WARN] = warn;
    status_word[hbfc_pkg::ST_LATCH] = latch_q;
    status_word[hbfc_pkg::ST_STATE_LSB +: 2] = state_q;
    status_word[hbfc_pkg::ST_LINE_LSB +: 3] = line_q;
  end

  // Events are levels; gated so reset and power-down stay quiet
  always_comb begin
    ev_now = '0;
    ev_now[hbfc_pkg::EV_ILLEGAL]  = illegal;
    ev_now[hbfc_pkg::EV_SHORT]    = latch_q;
    ev_now[hbfc_pkg::EV_OVERTEMP] = hot_q && armed;
    ev_now[hbfc_pkg::EV_LOWREG]   = low_reg && armed;
    ev_now[hbfc_pkg::EV_WARN]     = warn && armed;
  end

  always_comb begin
    ack_d  = bus_req && !ack_q;
    rdat_d = rdat_q;
    mute_d = mute_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (bus_req && !ack_q) begin
      rdat_d = '0;
      case (WB_ADR_I)
        hbfc_pkg::REG_CTRL: begin
          rdat_d[hbfc_pkg::CTRL_MUTE] = mute_q;
        end
        hbfc_pkg::REG_STATUS: begin
          rdat_d = status_word;
        end
        hbfc_pkg::REG_IRQ_STAT: begin
          rdat_d[hbfc_pkg::EV_W-1:0] = stat_q;
        end
        hbfc_pkg::REG_IRQ_MASK: begin
          rdat_d[hbfc_pkg::EV_W-1:0] = mask_q;
        end
        default: begin
          rdat_d = '0;
        end
      endcase
    end
    if (wr_hit) begin
      case (WB_ADR_I)
        hbfc_pkg::REG_CTRL: begin
          mute_d = WB_DAT_I[hbfc_pkg::CTRL_MUTE];
        end
        hbfc_pkg::REG_IRQ_STAT: begin
          stat_d = stat_q & ~WB_DAT_I[hbfc_pkg::EV_W-1:0];
        end
        hbfc_pkg::REG_IRQ_MASK: begin
          mask_d = WB_DAT_I[hbfc_pkg::EV_W-1:0];
        end
        default: begin
          mute_d = mute_q;
        end
      endcase
    end
    // A new event beats a clear in the same cycle
    stat_d = stat_d | ev_now;
    // Mask bit set means that event stays off the line
    irq_d  = |(stat_q & ~mask_q);
    line_d = {SHUTDOWN_N_I, FAULT_CODE_HI_I, FAULT_CODE_LO_I};
  end

  // ----------------------------------------------------------------
  // Pin drive from the next state
  // ----------------------------------------------------------------
  always_comb begin
    drv_d       = '0;
    oe_d        = '0;
    sd_pull_d   = 1'b0;
    code_pull_d = '0;
    case (state_d)
      hbfc_pkg::ST_OFF: begin
        // Everything let go, the pull-ups read high
        oe_d = '0;
      end
      hbfc_pkg::ST_HOLD: begin
        oe_d = '1;
      end
      hbfc_pkg::ST_RUN: begin
        oe_d = '1;
        if (!mute_q) begin
          drv_d = pos_in;
        end
        if (warn) begin
          code_pull_d = ~hbfc_pkg::CODE_WARN;
        end
      end
      hbfc_pkg::ST_FAULT: begin
        sd_pull_d   = 1'b1;
        code_pull_d = ~cause;
        if (latch_q) begin
          oe_d = '0;
        end else begin
          oe_d = '1;
        end
      end
      default: begin
        oe_d = '0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state_q     <= hbfc_pkg::ST_OFF;
      ack_q       <= 1'b0;
      rdat_q      <= '0;
      mute_q      <= hbfc_pkg::CTRL_RST;
      mask_q      <= hbfc_pkg::EV_RST;
      stat_q      <= hbfc_pkg::EV_RST;
      irq_q       <= 1'b0;
      line_q      <= '1;
      drv_q       <= '0;
      oe_q        <= '0;
      sd_pull_q   <= 1'b0;
      code_pull_q <= '0;
    end else begin
      state_q     <= state_d;
      ack_q       <= ack_d;
      rdat_q      <= rdat_d;
      mute_q      <= mute_d;
      mask_q      <= mask_d;
      stat_q      <= stat_d;
      irq_q       <= irq_d;
      line_q      <= line_d;
      drv_q       <= drv_d;
      oe_q        <= oe_d;
      sd_pull_q   <= sd_pull_d;
      code_pull_q <= code_pull_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign BRIDGE_OUT_A     = drv_q[0];
  assign BRIDGE_OUT_A_OE  = oe_q[0];
  assign BRIDGE_OUT_B     = drv_q[1];
  assign BRIDGE_OUT_B_OE  = oe_q[1];

  // Open drain: level is always low, only the enable moves
  assign SHUTDOWN_N_O     = 1'b0;
  assign SHUTDOWN_N_OE    = sd_pull_q;
  assign FAULT_CODE_HI_O  = 1'b0;
  assign FAULT_CODE_HI_OE = code_pull_q[1];
  assign FAULT_CODE_LO_O  = 1'b0;
  assign FAULT_CODE_LO_OE = code_pull_q[0];

  assign WB_DAT_O = rdat_q;
  assign WB_ACK_O = ack_q;
  assign IRQ      = irq_q;

endmodule : hbfc_top

/* hbfc_chk.sv */
// Checker for bridge output control and fault lines
`timescale 1ns/1ps
module hbfc_chk (
  // Clock, reset and control
  input wire logic SYS_CLK, RST_N, POWER_DOWN_N, BRIDGE_RESET_N,
  // Sensed inputs
  input wire logic SIDE_A_POS_IN, SIDE_A_NEG_IN,
  input wire logic OVER_CURRENT_A, OVER_CURRENT_B,
  // Bridge and fault line drivers
  input wire logic BRIDGE_OUT_A, BRIDGE_OUT_A_OE,
  input wire logic BRIDGE_OUT_B, BRIDGE_OUT_B_OE,
  input wire logic SHUTDOWN_N_O, SHUTDOWN_N_OE,
  input wire logic FAULT_CODE_HI_O, FAULT_CODE_HI_OE,
  input wire logic FAULT_CODE_LO_O, FAULT_CODE_LO_OE
);
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  // Latency is not fixed, so outputs get four cycles to settle
  wire run = POWER_DOWN_N && BRIDGE_RESET_N;
  wire flt = run && SHUTDOWN_N_OE && !BRIDGE_OUT_A_OE;
  a_pdn_float: assert property ((!POWER_DOWN_N)[*4] |->
    !BRIDGE_OUT_A_OE && !BRIDGE_OUT_B_OE) else $error("bridge driven");
  a_pdn_release: assert property ((!POWER_DOWN_N)[*4] |->
    !SHUTDOWN_N_OE && !FAULT_CODE_HI_OE && !FAULT_CODE_LO_OE)
    else $error("fault line held in power-down");
  a_od_never_high: assert property ((SHUTDOWN_N_OE -> !SHUTDOWN_N_O) &&
    (FAULT_CODE_HI_OE -> !FAULT_CODE_HI_O) &&
    (FAULT_CODE_LO_OE -> !FAULT_CODE_LO_O)) else $error("line driven high");
  a_reset_low: assert property ((POWER_DOWN_N && !BRIDGE_RESET_N)[*4] |->
    BRIDGE_OUT_A_OE && BRIDGE_OUT_B_OE && !BRIDGE_OUT_A && !BRIDGE_OUT_B)
    else $error("bridge not low in reset");
  a_short_float: assert property (run && (OVER_CURRENT_A || OVER_CURRENT_B)
    ##1 run[*4] |-> !BRIDGE_OUT_A_OE && !BRIDGE_OUT_B_OE)
    else $error("short did not float bridge");
  a_short_hold: assert property (flt |=> !run || !BRIDGE_OUT_A_OE)
    else $error("short latch lost");
  a_short_code: assert property (flt[*3] |->
    FAULT_CODE_HI_OE && !FAULT_CODE_LO_OE) else $error("short code wrong");
  a_illegal_low: assert property (
    (run && SIDE_A_POS_IN == SIDE_A_NEG_IN)[*4] |-> SHUTDOWN_N_OE &&
    !(BRIDGE_OUT_A_OE && BRIDGE_OUT_A)) else $error("equal pair not shut");
  a_normal_follow: assert property ((run && !SHUTDOWN_N_OE &&
    $stable(SIDE_A_POS_IN) && SIDE_A_POS_IN != SIDE_A_NEG_IN)[*4] |->
    BRIDGE_OUT_A_OE && BRIDGE_OUT_A == SIDE_A_POS_IN)
    else $error("bridge does not follow input");
endmodule : hbfc_chk

bind hbfc_top hbfc_chk u_hbfc_chk (
  .SYS_CLK, .RST_N, .POWER_DOWN_N, .BRIDGE_RESET_N, .SIDE_A_POS_IN,
  .SIDE_A_NEG_IN, .OVER_CURRENT_A, .OVER_CURRENT_B, .BRIDGE_OUT_A,
  .BRIDGE_OUT_A_OE, .BRIDGE_OUT_B, .BRIDGE_OUT_B_OE, .SHUTDOWN_N_O,
  .SHUTDOWN_N_OE, .FAULT_CODE_HI_O, .FAULT_CODE_HI_OE, .FAULT_CODE_LO_O,
  .FAULT_CODE_LO_OE
);

/* hbfc_mod_model.sv */
// Upstream modulator model: PWM pairs and valid output
`timescale 1ns/1ps
module hbfc_mod_model #(parameter int HOLD = 25000) (
  input  wire logic       clk,
  input  wire logic       restart,
  input  wire logic [1:0] mode,
  output logic            valid,
  output logic            ap, an, bp, bn
);
  int         cnt_q = HOLD;
  logic [2:0] div_q = 3'h0;
  always @(posedge clk) begin
    cnt_q <= restart ? HOLD : (cnt_q > 0 ? cnt_q - 1 : 0);
    if (mode != 2'h1) div_q <= div_q + 3'h1;
  end
  assign valid = (cnt_q == 0);
  // Mode 2 forces an equal pair on side A
  assign ap = (mode == 2'h2) | div_q[2];
  assign an = (mode == 2'h2) | !div_q[2];
  assign bp = !div_q[2];
  assign bn = div_q[2];
endmodule : hbfc_mod_model

/* hbfc_top_tb.sv */
// Testbench for the bridge fault controller
`timescale 1ns/1ps
module hbfc_top_tb;
  logic SYS_CLK = 0, RST_N = 0, POWER_DOWN_N = 1, BRIDGE_RESET_N, restart = 1;
  logic SIDE_A_POS_IN, SIDE_A_NEG_IN, SIDE_B_POS_IN, SIDE_B_NEG_IN, IRQ;
  logic [7:0] TEMP_SENSE = 8'h19, WB_ADR_I = 8'h00;
  logic REGULATOR_OUT_A_OK = 1, REGULATOR_OUT_B_OK = 1, OVER_CURRENT_A = 0;
  logic OVER_CURRENT_B = 0, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0;
  logic [3:0] WB_SEL_I = 4'hf;
  logic [1:0] mode = 2'h0;
  logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, q;
  logic BRIDGE_OUT_A, BRIDGE_OUT_A_OE, BRIDGE_OUT_B, BRIDGE_OUT_B_OE, WB_ACK_O;
  logic SHUTDOWN_N_O, SHUTDOWN_N_OE, FAULT_CODE_HI_O, FAULT_CODE_HI_OE;
  logic FAULT_CODE_LO_O, FAULT_CODE_LO_OE;
  int err_count = 0, checks = 0, cyc_cnt = 0;
  // Pull-ups on the shared fault lines
  wire SHUTDOWN_N_I = SHUTDOWN_N_OE ? SHUTDOWN_N_O : 1'h1;
  wire FAULT_CODE_HI_I = FAULT_CODE_HI_OE ? FAULT_CODE_HI_O : 1'h1;
  wire FAULT_CODE_LO_I = FAULT_CODE_LO_OE ? FAULT_CODE_LO_O : 1'h1;
  // Output level only counts while driven in shutdown
  wire [4:0] v = {SHUTDOWN_N_I, FAULT_CODE_HI_I, FAULT_CODE_LO_I,
    BRIDGE_OUT_A_OE, BRIDGE_OUT_A & BRIDGE_OUT_A_OE & !SHUTDOWN_N_I};
  hbfc_mod_model u_hbfc_mod_model (.clk(SYS_CLK), .restart, .mode,
    .valid(BRIDGE_RESET_N), .ap(SIDE_A_POS_IN), .an(SIDE_A_NEG_IN),
    .bp(SIDE_B_POS_IN), .bn(SIDE_B_NEG_IN));
  hbfc_top u_hbfc_top (.SYS_CLK, .RST_N, .POWER_DOWN_N, .BRIDGE_RESET_N,
    .SIDE_A_POS_IN, .SIDE_A_NEG_IN, .SIDE_B_POS_IN, .SIDE_B_NEG_IN,
    .TEMP_SENSE, .REGULATOR_OUT_A_OK, .REGULATOR_OUT_B_OK, .OVER_CURRENT_A,
    .OVER_CURRENT_B, .BRIDGE_OUT_A, .BRIDGE_OUT_A_OE, .BRIDGE_OUT_B,
    .BRIDGE_OUT_B_OE, .SHUTDOWN_N_O, .SHUTDOWN_N_OE, .SHUTDOWN_N_I,
    .FAULT_CODE_HI_O, .FAULT_CODE_HI_OE, .FAULT_CODE_HI_I, .FAULT_CODE_LO_O,
    .FAULT_CODE_LO_OE, .FAULT_CODE_LO_I, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
    .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .IRQ);
  initial forever #20 SYS_CLK = ~SYS_CLK;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input logic [4:0] g, e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %0t got %h want %h", $time, g, e);
    end
  endtask : cmp
  task automatic want(input logic [4:0] e, input int n);
    for (int i = 0; i < n && v !== e; i++) @(posedge SYS_CLK);
    cmp(v, e);
  endtask : want
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    {WB_CYC_I, WB_STB_I, WB_WE_I} <= {2'h3, w};
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    do @(posedge SYS_CLK); while (WB_ACK_O !== 1'h1);
    q = WB_DAT_O;
    {WB_CYC_I, WB_STB_I} <= 2'h0;
  endtask : wb
  task automatic breset;
    restart <= 1'h1;
    repeat (2) @(posedge SYS_CLK);
    restart <= 1'h0;
    wait (BRIDGE_RESET_N === 1'h1);
  endtask : breset
  always @(posedge SYS_CLK) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 60000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge SYS_CLK);
    RST_N <= 1'h1;
    restart <= 1'h0;
    want(5'h1e, 30);
    wait (BRIDGE_RESET_N === 1'h1);
    want(5'h1e, 30);
    TEMP_SENSE <= 8'h87;
    want(5'h1a, 30);
    TEMP_SENSE <= 8'h97;
    want(5'h0a, 30);
    TEMP_SENSE <= 8'h8c;
    repeat (20) @(posedge SYS_CLK);
    want(5'h0a, 0);
    TEMP_SENSE <= 8'h19;
    want(5'h1e, 30);
    REGULATOR_OUT_B_OK <= 1'h0;
    want(5'h0e, 30);
    REGULATOR_OUT_B_OK <= 1'h1;
    want(5'h1e, 30);
    mode <= 2'h2;
    want(5'h02, 30);
    mode <= 2'h0;
    want(5'h1e, 30);
    mode <= 2'h1;
    want(5'h02, 700);
    mode <= 2'h0;
    want(5'h1e, 30);
    wb(1'h0, hbfc_pkg::REG_STATUS, 32'h0);
    cmp(q[hbfc_pkg::ST_SHUT], 1'h0);
    wb(1'h1, hbfc_pkg::REG_CTRL, 32'h1);
    repeat (2) @(posedge SYS_CLK);
    repeat (8) begin
      @(posedge SYS_CLK);
      cmp({BRIDGE_OUT_A, BRIDGE_OUT_B}, 2'h0);
    end
    wb(1'h1, hbfc_pkg::REG_CTRL, 32'h0);
    wb(1'h1, hbfc_pkg::REG_IRQ_MASK, 32'h1f);
    wb(1'h1, hbfc_pkg::REG_IRQ_STAT, 32'h1f);
    TEMP_SENSE <= 8'h97;
    OVER_CURRENT_A <= 1'h1;
    want(5'h04, 30);
    {OVER_CURRENT_A, TEMP_SENSE} <= {1'h0, 8'h19};
    repeat (20) @(posedge SYS_CLK);
    want(5'h04, 0);
    cmp(IRQ, 1'h0);
    wb(1'h0, hbfc_pkg::REG_IRQ_STAT, 32'h0);
    cmp(q[hbfc_pkg::EV_SHORT], 1'h1);
    wb(1'h1, hbfc_pkg::REG_IRQ_MASK, 32'h0);
    repeat (2) @(posedge SYS_CLK);
    cmp(IRQ, 1'h1);
    breset();
    want(5'h1e, 30);
    wb(1'h1, hbfc_pkg::REG_IRQ_STAT, 32'h1f);
    repeat (2) @(posedge SYS_CLK);
    cmp(IRQ, 1'h0);
    wb(1'h0, 8'h40, 32'h0);
    {restart, POWER_DOWN_N} <= 2'h2;
    want(5'h1c, 30);
    cmp(BRIDGE_OUT_B_OE, 1'h0);
    tally_and_finish();
  end
endmodule : hbfc_top_tb
